// ==== rtl/byte_fifo.v ====
module byte_fifo #(
  parameter WIDTH = 8,
  parameter AW = 4,
  parameter [AW:0] DEPTH = 16
) (
  input wire sys_clk,
  input wire reset,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output reg inReady,
  output wire [WIDTH-1:0] outData,
  output reg outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  wire push;
  wire pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_reg];

  always @* begin
    count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // flags registered from next count, so they are exact every cycle
  always @(posedge sys_clk) begin
    if (reset) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        mem[wrPtr_reg] <= inData;
        wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      count_reg <= count_next;
      inReady <= (count_next != DEPTH);
      outValid <= (count_next != {(AW+1){1'b0}});
    end
  end
endmodule // byte_fifo

// ==== rtl/eeprom_host.v ====
`include "eeprom_host_map.vh"

// Summary of operation
// - every transaction opens with data falling while clock is high.
// - stop is data rising while clock is high, ending every command.
// - data changes only while clock is low; high-clock changes are start/stop.
// - bytes are eight bits; receiver pulls data low on the ninth clock.
// - address byte is four type bits, three select bits, direction bit.
// - byte write is address, high and low word address, one data byte.
// - controller keeps write-protect steady from start to stop of writes.
// - polling repeats start and read address until acknowledged; the controller tries once per command and the caller repeats it.
// - random read loads address with dummy write, then restarts reading.
// - acknowledged read byte brings the next; stop after no-ack ends it.
// - recovery is start, nine released clocks, start, then stop.
module eeprom_host #(
  parameter [3:0] DEVICE_CODE = 4'h5 // arbitrary value, set to the part's code
) (
  input wire sys_clk,
  input wire reset,
  input wire cmdValid,
  output reg cmdReady,
  input wire [`OP_W-1:0] cmdOp,
  input wire [15:0] cmdAddr,
  input wire [7:0] cmdLen,
  input wire [2:0] cmdTarget,
  input wire cmdWp,
  input wire [7:0] wrData,
  input wire wrValid,
  output wire wrReady,
  output reg [7:0] rdData,
  output reg rdValid,
  output reg done,
  output reg nackErr,
  output reg scl,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  output reg wp
);
  reg sdaMeta_reg;
  reg sdaSync_reg;
  reg [`DIV_W-1:0] div_reg;
  reg tick_reg;
  reg [`ST_W-1:0] state_reg;
  reg [`STG_W-1:0] stage_reg;
  reg [`OP_W-1:0] op_reg;
  reg [1:0] phase_reg;
  reg [3:0] bitCnt_reg;
  reg [7:0] shift_reg;
  reg [15:0] addr_reg;
  reg [2:0] target_reg;
  reg [7:0] rem_reg;
  reg ackBit_reg;
  wire [7:0] fifoData;
  wire fifoValid;
  wire fifoPop;

  function [7:0] devByte;
    input [3:0] code;
    input [2:0] sel;
    input dir;
    begin
      devByte = {code, sel, dir};
    end
  endfunction

  // write data is only drained when the bus is ready for the next byte
  assign fifoPop = (state_reg == `ST_LOAD) && (stage_reg == `STG_DATA) &&
                   fifoValid;

  byte_fifo #(
    .WIDTH(8),
    .AW(4),
    .DEPTH(5'd16)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .inData(wrData),
    .inValid(wrValid),
    .inReady(wrReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  always @(posedge sys_clk) begin
    if (reset) begin
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      div_reg <= {`DIV_W{1'b0}};
      tick_reg <= 1'b0;
    end else begin
      sdaMeta_reg <= sdaIn;
      sdaSync_reg <= sdaMeta_reg;
      tick_reg <= (div_reg == `DIV_LAST);
      div_reg <= (div_reg == `DIV_LAST) ? {`DIV_W{1'b0}} :
                 div_reg + {{(`DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= `ST_IDLE;
      stage_reg <= `STG_DEV;
      op_reg <= `OP_WRITE;
      phase_reg <= `PH_SET;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= 16'h0000;
      target_reg <= 3'h0;
      rem_reg <= `LEN_ZERO;
      ackBit_reg <= 1'b1;
      cmdReady <= 1'b0;
      rdData <= 8'h00;
      rdValid <= 1'b0;
      done <= 1'b0;
      nackErr <= 1'b0;
      scl <= 1'b1;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      wp <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      done <= 1'b0;
      sdaOut <= 1'b0;
      if (state_reg == `ST_IDLE) begin
        cmdReady <= 1'b1;
        scl <= 1'b1;
        sdaOe <= 1'b0;
        if (cmdValid && cmdReady) begin
          cmdReady <= 1'b0;
          nackErr <= 1'b0;
          op_reg <= cmdOp;
          addr_reg <= cmdAddr;
          target_reg <= cmdTarget;
          // held until the next command so it never moves mid-write
          wp <= cmdWp;
          rem_reg <= cmdLen;
          if ((cmdOp == `OP_READ_CUR || cmdOp == `OP_READ_RAND) &&
              cmdLen == `LEN_ZERO) begin
            rem_reg <= `LEN_ONE;
          end
          case (cmdOp)
            `OP_READ_CUR: stage_reg <= `STG_RDEV;
            `OP_POLL: stage_reg <= `STG_POLL;
            `OP_RECOVER: stage_reg <= `STG_DUMMY;
            default: stage_reg <= `STG_DEV;
          endcase
          phase_reg <= `PH_SET;
          state_reg <= `ST_START;
        end
      end else if (state_reg == `ST_LOAD) begin
        // phase is already back at PH_SET here
        bitCnt_reg <= 4'h0;
        case (stage_reg)
          `STG_DATA: begin
            if (fifoValid) begin
              shift_reg <= fifoData;
              state_reg <= `ST_TX;
            end
          end
          `STG_AHI: begin
            shift_reg <= addr_reg[15:8];
            state_reg <= `ST_TX;
          end
          `STG_ALO: begin
            shift_reg <= addr_reg[7:0];
            state_reg <= `ST_TX;
          end
          `STG_DEV: begin
            shift_reg <= devByte(DEVICE_CODE, target_reg, `DIR_WRITE);
            state_reg <= `ST_TX;
          end
          default: begin
            shift_reg <= devByte(DEVICE_CODE, target_reg, `DIR_READ);
            state_reg <= `ST_TX;
          end
        endcase
      end else if (tick_reg) begin
        phase_reg <= phase_reg + 2'h1;
        case (state_reg)
          `ST_START: begin
            case (phase_reg)
              `PH_SET: sdaOe <= 1'b0;
              `PH_RISE: scl <= 1'b1;
              `PH_SAMPLE: sdaOe <= 1'b1;
              default: begin
                scl <= 1'b0;
                bitCnt_reg <= 4'h0;
                if (stage_reg == `STG_DUMMY) begin
                  state_reg <= `ST_DUMMY;
                end else if (stage_reg == `STG_RECOV) begin
                  state_reg <= `ST_STOP;
                end else begin
                  state_reg <= `ST_LOAD;
                end
              end
            endcase
          end
          `ST_TX: begin
            case (phase_reg)
              `PH_SET: begin
                // only moves with the clock low
                sdaOe <= (bitCnt_reg == `BIT_ACK) ? 1'b0 : ~shift_reg[7];
              end
              `PH_RISE: scl <= 1'b1;
              `PH_SAMPLE: begin
                if (bitCnt_reg == `BIT_ACK) begin
                  ackBit_reg <= sdaSync_reg;
                end
              end
              default: begin
                scl <= 1'b0;
                shift_reg <= {shift_reg[6:0], 1'b0};
                bitCnt_reg <= bitCnt_reg + 4'h1;
                if (bitCnt_reg == `BIT_ACK) begin
                  bitCnt_reg <= 4'h0;
                  if (ackBit_reg) begin
                    // busy, absent or protected memory all end here
                    nackErr <= 1'b1;
                    state_reg <= `ST_STOP;
                  end else begin
                    case (stage_reg)
                      `STG_DEV: begin
                        stage_reg <= `STG_AHI;
                        state_reg <= `ST_LOAD;
                      end
                      `STG_AHI: begin
                        stage_reg <= `STG_ALO;
                        state_reg <= `ST_LOAD;
                      end
                      `STG_ALO: begin
                        if (op_reg == `OP_READ_RAND) begin
                          stage_reg <= `STG_RDEV;
                          state_reg <= `ST_START;
                        end else if (rem_reg == `LEN_ZERO) begin
                          state_reg <= `ST_STOP;
                        end else begin
                          stage_reg <= `STG_DATA;
                          state_reg <= `ST_LOAD;
                        end
                      end
                      `STG_DATA: begin
                        rem_reg <= rem_reg - `LEN_ONE;
                        // stop right after the last ack starts the write
                        if (rem_reg == `LEN_ONE) begin
                          state_reg <= `ST_STOP;
                        end else begin
                          state_reg <= `ST_LOAD;
                        end
                      end
                      `STG_POLL: begin
                        // memory now drives data, so take one byte first
                        rem_reg <= `LEN_ONE;
                        state_reg <= `ST_RX;
                      end
                      default: state_reg <= `ST_RX;
                    endcase
                  end
                end
              end
            endcase
          end
          `ST_RX: begin
            case (phase_reg)
              `PH_SET: begin
                sdaOe <= (bitCnt_reg == `BIT_ACK) &&
                         (rem_reg != `LEN_ONE);
              end
              `PH_RISE: scl <= 1'b1;
              `PH_SAMPLE: begin
                if (bitCnt_reg != `BIT_ACK) begin
                  shift_reg <= {shift_reg[6:0], sdaSync_reg};
                end
              end
              default: begin
                scl <= 1'b0;
                bitCnt_reg <= bitCnt_reg + 4'h1;
                if (bitCnt_reg == `BIT_LAST_DATA) begin
                  rdData <= shift_reg;
                  rdValid <= 1'b1;
                end
                if (bitCnt_reg == `BIT_ACK) begin
                  bitCnt_reg <= 4'h0;
                  rem_reg <= rem_reg - `LEN_ONE;
                  if (rem_reg == `LEN_ONE) begin
                    state_reg <= `ST_STOP;
                  end
                end
              end
            endcase
          end
          `ST_DUMMY: begin
            case (phase_reg)
              `PH_SET: sdaOe <= 1'b0;
              `PH_RISE: scl <= 1'b1;
              `PH_SAMPLE: scl <= 1'b1;
              default: begin
                scl <= 1'b0;
                bitCnt_reg <= bitCnt_reg + 4'h1;
                if (bitCnt_reg == `BIT_ACK) begin
                  stage_reg <= `STG_RECOV;
                  state_reg <= `ST_START;
                end
              end
            endcase
          end
          `ST_STOP: begin
            case (phase_reg)
              `PH_SET: sdaOe <= 1'b1;
              `PH_RISE: scl <= 1'b1;
              `PH_SAMPLE: sdaOe <= 1'b0;
              default: state_reg <= `ST_BUF;
            endcase
          end
          default: begin
            // one idle period of bus free time before the next start
            if (phase_reg == `PH_FALL) begin
              state_reg <= `ST_IDLE;
              done <= 1'b1;
            end
          end
        endcase
      end
    end
  end
endmodule // eeprom_host

// ==== shared/eeprom_host_map.vh ====
`ifndef EEPROM_HOST_MAP_VH
`define EEPROM_HOST_MAP_VH

// timing
`define CLK_PERIOD_NS 40
`define SCL_QUARTER_NS 2500
// least time, so round up
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIV_W 7
`define DIV_LAST (7'd0 + `SCL_QUARTER_CYC - 7'd1)

// commands
`define OP_W 3
`define OP_WRITE 3'h0
`define OP_READ_CUR 3'h1
`define OP_READ_RAND 3'h2
`define OP_POLL 3'h3
`define OP_RECOVER 3'h4

// main states
`define ST_W 3
`define ST_IDLE 3'h0
`define ST_START 3'h1
`define ST_LOAD 3'h2
`define ST_TX 3'h3
`define ST_RX 3'h4
`define ST_DUMMY 3'h5
`define ST_STOP 3'h6
`define ST_BUF 3'h7

// byte stages within a transaction
`define STG_W 3
`define STG_DEV 3'h0
`define STG_AHI 3'h1
`define STG_ALO 3'h2
`define STG_DATA 3'h3
`define STG_RDEV 3'h4
`define STG_POLL 3'h5
`define STG_DUMMY 3'h6
`define STG_RECOV 3'h7

// quarter phases of one serial clock period
`define PH_SET 2'h0
`define PH_RISE 2'h1
`define PH_SAMPLE 2'h2
`define PH_FALL 2'h3

`define BIT_ACK 4'h8
`define BIT_LAST_DATA 4'h7
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
`define LEN_ONE 8'h01
`define LEN_ZERO 8'h00

`endif

// ==== testbench/eeprom_host_asserts.sv ====
module eeprom_host_asserts (
  input wire sys_clk,
  input wire reset,
  input wire cmdValid,
  input wire cmdReady,
  input wire cmdWp,
  input wire done,
  input wire nackErr,
  input wire rdValid,
  input wire scl,
  input wire sdaOut,
  input wire sdaOe,
  input wire wp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclQ;
  logic fresh;
  logic [6:0] hold;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  always @(posedge sys_clk) begin
    sclQ <= scl;
    fresh <= !reset && (cmdReady || (fresh && scl));
    if (reset || scl != sclQ) hold <= 7'h0;
    else if (hold != 7'h7f) hold <= hold + 7'h1;
  end
  chk_sda_drain: assert property (sdaOut == 1'b0)
    else $error("data output driven high");
  chk_idle_bus: assert property (
    cmdReady && $past(cmdReady) |-> scl && !sdaOe)
    else $error("bus not free while idle");
  chk_wp_held: assert property (
    !cmdReady && !$past(cmdReady) |-> $stable(wp))
    else $error("protect level moved mid command");
  chk_wp_copy: assert property (
    cmdValid && cmdReady |=> wp == $past(cmdWp))
    else $error("protect level not taken");
  chk_data_edge: assert property ($changed(sdaOe) |-> $stable(scl))
    else $error("data moved with clock edge");
  chk_scl_hold: assert property (scl != sclQ |-> hold >= 7'd62)
    else $error("clock level too short");
  chk_start_first: assert property (fresh && sclQ && !scl |-> sdaOe)
    else $error("command did not open with start");
  chk_done_once: assert property (done |=> cmdReady && !done)
    else $error("bad completion pulse");
  chk_nack_clear: assert property (
    cmdValid && cmdReady |-> ##[1:2] !nackErr)
    else $error("error flag not cleared");
  chk_rd_release: assert property (rdValid |-> !sdaOe && !cmdReady)
    else $error("read byte while data held");
endmodule // eeprom_host_asserts

bind eeprom_host eeprom_host_asserts eeprom_host_asserts_inst (.sys_clk,
  .reset, .cmdValid, .cmdReady, .cmdWp, .done, .nackErr, .rdValid, .scl,
  .sdaOut, .sdaOe, .wp);

// ==== testbench/eeprom_host_tb.sv ====
`include "eeprom_host_map.vh"
module eeprom_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [3:0] CODE = 4'h6; // arbitrary type code
  localparam [2:0] SEL = 3'h5;
  logic sys_clk, reset, cmdValid, cmdReady, cmdWp, wrValid, wrReady;
  logic rdValid, done, nackErr, scl, sdaOut, sdaOe, wp, devOe;
  logic [2:0] cmdOp, cmdTarget;
  logic [15:0] cmdAddr, a;
  logic [7:0] cmdLen, wrData, rdData;
  logic [7:0] d [0:16];
  logic [7:0] got [$];
  logic [31:0] seed = 32'd92891;
  int mismatches, comparisons, i, n;
  wire sda = !(sdaOe || devOe);

  eeprom_host #(.DEVICE_CODE(CODE)) eeprom_host_inst (.sys_clk, .reset,
    .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdLen, .cmdTarget, .cmdWp,
    .wrData, .wrValid, .wrReady, .rdData, .rdValid, .done, .nackErr, .scl,
    .sdaIn(sda), .sdaOut, .sdaOe, .wp);
  eeprom_model #(.CODE(CODE), .SEL(SEL)) eeprom_model_inst (.scl, .sda,
    .wpPin(wp), .devOe);

  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (rdValid === 1'b1) got.push_back(rdData);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] fill(input logic [15:0] x);
    return x[7:0] ^ 8'h5a;
  endfunction
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic run(input logic [2:0] op, input logic [15:0] ad,
      input logic [7:0] len, input logic w, input logic [2:0] t);
    int k;
    got = {};
    {cmdOp, cmdAddr, cmdLen, cmdWp, cmdTarget} = {op, ad, len, w, t};
    cmdValid = 1;
    for (k = 0; k < 99 && cmdReady !== 1'b1; k++) tick;
    if (k >= 99) begin
      mismatches++;
      print_verdict;
    end
    tick;
    cmdValid = 0;
    for (k = 0; k < 60000 && done !== 1'b1; k++) tick;
    if (k >= 60000) begin
      mismatches++;
      print_verdict;
    end
  endtask
  task automatic push(input int lo, input int hi);
    int k;
    wrValid = 1;
    for (int j = lo; j <= hi; j++) begin
      wrData = d[j];
      for (k = 0; k < 9999 && wrReady !== 1'b1; k++) tick;
      if (k >= 9999) begin
        mismatches++;
        print_verdict;
      end
      tick;
    end
    wrValid = 0;
  endtask

  initial begin
    {cmdValid, cmdOp, cmdAddr, cmdLen, cmdTarget, cmdWp} = '0;
    {wrData, wrValid} = '0;
    reset = 1;
    repeat (8) tick;
    reset = 0;
    tick;
    for (int j = 0; j < 17; j++) begin
      seed = lfsr(seed);
      d[j] = seed[7:0];
    end
    // page kept off the first and last page used by the wrap reads
    a = {1'b0, seed[23:17], 1'b1, 7'h7e};
    push(0, 15);
    tick;
    check(wrReady, 1'b0);
    // last byte arrives only once the host has stalled the clock
    fork
      run(`OP_WRITE, a, 8'd17, 1'b0, SEL);
      begin
        n = 0;
        for (i = 0; i < 60000 && n < 400; i++) begin
          tick;
          n = scl ? 0 : n + 1;
        end
        if (n < 400) begin
          mismatches++;
          print_verdict;
        end
        push(16, 16);
      end
    join
    check(nackErr, 1'b0);
    run(`OP_POLL, a, 8'd0, 1'b0, SEL);
    check(nackErr, 1'b1);
    for (i = 0; i < 9 && nackErr !== 1'b0; i++)
      run(`OP_POLL, a, 8'd0, 1'b0, SEL);
    check(nackErr, 1'b0);
    // dummy write only loads the counter, then read on from there
    run(`OP_WRITE, {a[15:7], 7'h0e}, 8'd0, 1'b0, SEL);
    check(nackErr, 1'b0);
    run(`OP_READ_CUR, a, 8'd2, 1'b0, SEL);
    check(got[0], d[16]);
    check(got[1], fill({a[15:7], 7'h0f}));
    push(0, 0);
    run(`OP_WRITE, 16'hffff, 8'd1, 1'b1, SEL);
    check(nackErr, 1'b1);
    check(wp, 1'b1);
    run(`OP_READ_RAND, 16'hffff, 8'd2, 1'b0, SEL);
    check(got[0], fill(16'hffff));
    check(got[1], fill(16'h0000));
    check(wp, 1'b0);
    run(`OP_RECOVER, a, 8'd0, 1'b0, SEL);
    check(nackErr, 1'b0);
    run(`OP_READ_CUR, a, 8'd1, 1'b0, SEL ^ (seed[2:0] | 3'h1));
    check(nackErr, 1'b1);
    run(`OP_READ_CUR, a, 8'd1, 1'b0, SEL);
    check(got[0], fill(16'h0001));
    print_verdict;
  end
endmodule // eeprom_host_tb

// ==== testbench/eeprom_model.sv ====
module eeprom_model #(
  parameter [3:0] CODE = 4'h6, // arbitrary value
  parameter [2:0] SEL = 3'h0,
  parameter BUSY = 120000
) (
  input wire scl,
  input wire sda,
  input wire wpPin,
  output logic devOe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] pend [0:127];
  logic [7:0] sh, ob;
  logic [127:0] pv;
  logic [15:0] ptr;
  logic busy, rd, mack, okStop;
  int bc, stg, n;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
    devOe = 0;
    busy = 0;
  end
  // start resets protocol state; ignored while writing
  always @(negedge sda) if (scl) begin
    stg = busy ? 0 : 1;
    bc = 0;
    devOe = 0;
  end
  always @(posedge sda) if (scl) begin
    if (stg == 4 && okStop && n > 0 && !wpPin) begin
      for (int k = 0; k < 128; k++)
        if (pv[k]) mem[{ptr[15:7], k[6:0]}] = pend[k];
      busy = 1;
      busy <= #BUSY 1'b0;
    end
    stg = 0;
    devOe = 0;
  end
  always @(posedge scl) if (stg != 0) begin
    bc++;
    if (bc < 9) sh = {sh[6:0], sda};
    else mack = !sda;
  end
  always @(negedge scl) if (stg != 0) begin
    if (bc == 8) begin
      devOe = 1;
      case (stg)
        1: if (sh[7:4] != CODE || sh[3:1] != SEL) begin
          devOe = 0;
          stg = 0;
        end else rd = sh[0];
        2: ptr[15:8] = sh;
        3: begin
          ptr[7:0] = sh;
          pv = '0;
          n = 0;
        end
        4: if (wpPin) devOe = 0;
        else begin
          pend[ptr[6:0]] = sh;
          pv[ptr[6:0]] = 1'b1;
          n++;
          ptr[6:0] = ptr[6:0] + 7'h1;
        end
        default: begin
          devOe = 0;
          ptr = ptr + 16'h1;
        end
      endcase
    end else if (bc == 9) begin
      devOe = 0;
      bc = 0;
      okStop = stg == 4;
      if (stg == 1) stg = rd ? 5 : 2;
      else if (stg < 4) stg++;
      else if (stg == 5 && !mack) stg = 0;
      if (stg == 5) ob = mem[ptr];
    end else okStop = 0;
    if (stg == 5 && bc < 8) devOe = !ob[7 - bc];
  end
endmodule // eeprom_model
